// ==== testbench/odcs_host.sv ====
// Host controller model driving the serial link
`default_nettype none
module odcs_host (
	input  wire logic clk_i,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output logic      sclk_o,
	output logic      sync_n_o,
	output logic      sdin_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle link: clock high, frame sync high
	initial begin
		sclk_o = 1'b1;
		sync_n_o = 1'b1;
		sdin_o = 1'b0;
	end

	// Waits n edges, then steps off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Checksum over the data word, MSB first
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	// One frame; flip corrupts the checksum, rd gathers readback
	task automatic xfer(input logic [15:0] w, input logic ext, input logic [7:0] flip,
		output logic [15:0] rd, output logic drv);
		logic [23:0] f;
		f = {w, crc8(w) ^ flip};
		rd = 16'h0000;
		drv = 1'b0;
		sync_n_o = 1'b0;
		tick(4);
		for (int i = 0; i < (ext ? 24 : 16); i++) begin
			sdin_o = f[23-i];
			tick(4);
			sclk_o = 1'b0;
			tick(4);
			if (i >= 5 && i <= 20) begin
				// Undriven line reads as inverse of last bit
				rd = {rd[14:0], sdo_oe_i ? sdo_i : ~rd[0]};
				drv = drv | sdo_oe_i;
			end
			sclk_o = 1'b1;
		end
		tick(4);
		sync_n_o = 1'b1;
		tick(8);
	endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the output driver configuration block
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        sclk, sync_n, sdin, sdo, sdo_oe, drv;
	logic        hw = 1'b0, rpin = 1'b0, det_i = 1'b0, det_v = 1'b0, det_t = 1'b0;
	logic        fn, f_oe, cf, cf_oe, vf, vf_oe, tf, tf_oe, iov, oen, clf, clm, hwm;
	logic        rs, cl, en;
	logic [2:0]  addr = 3'h5;
	logic [3:0]  rpins = 4'h0, rng;
	logic [4:0]  rc;
	logic [15:0] r, seen;
	logic [31:0] rv;
	logic [15:0] q[$];
	int          fail_count = 0;
	int          checks_done = 0;
	event        got;

	always #4 clk_i = ~clk_i;

	odcs_host i_odcs_host (.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sclk_o(sclk),
		.sync_n_o(sync_n), .sdin_o(sdin));

	odcs_top i_odcs_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .sync_n_i(sync_n),
		.sdin_i(sdin), .hardware_mode_select_i(hw), .device_address_i(addr), .range_pins_i(rpins),
		.sense_resistor_pin_i(rpin), .current_output_pin_open_det_i(det_i), .voltage_output_pin_short_det_i(det_v),
		.overtemp_det_i(det_t), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .fault_n_o(fn), .fault_n_oe_o(f_oe),
		.current_loop_fault_out_o(cf), .current_loop_fault_out_oe_o(cf_oe),
		.voltage_short_fault_out_o(vf), .voltage_short_fault_out_oe_o(vf_oe),
		.overtemp_fault_out_o(tf), .overtemp_fault_out_oe_o(tf_oe), .range_code_o(rc),
		.internal_overrange_o(iov), .output_drive_enable_o(oen), .clear_force_o(clf),
		.clear_midscale_o(clm), .hw_mode_o(hwm));

	// Compare and count
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Verdict and end of run
	task automatic results();
		$display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Write frame, result ignored
	task automatic wr(input logic [15:0] w, input logic ext, input logic [7:0] flip);
		i_odcs_host.xfer(w, ext, flip, r, drv);
	endtask

	// Addressed read, expected word noted first
	task automatic rd(input logic [15:0] e);
		q.push_back(e);
		i_odcs_host.xfer({addr, 1'b1, 12'h000}, 1'b1, 8'h00, seen, drv);
		->got;
	endtask

	task automatic do_reset();
		sys_rst_i = 1'b1;
		i_odcs_host.tick(2);
		sys_rst_i = 1'b0;
		i_odcs_host.tick(6);
	endtask

	// Readback watcher takes the oldest note
	always @(got) check(seen, q.pop_front());

	// Watchdog: about 25 frames of some 210 cycles each, with a wide margin
	initial begin
		#500000;
		fail_count++;
		results();
	end

	// Main sequence
	initial begin
		void'($urandom(32'hBB2E));
		rv = $urandom;
		addr = rv[2:0];
		do_reset();
		check({sdo_oe, oen, rc, f_oe, fn}, 16'h0000);
		for (int k = 0; k < 6; k++) begin
			rv = $urandom;
			rng = (k < 3) ? 4'(4'hD + k) : rv[3:0];
			rs = (k < 3) ? 1'b1 : rv[4];
			cl = rv[5];
			en = rv[6];
			wr({addr, 2'b00, rng, cl, en, rs, 4'h0}, k[0], 8'h00);
			check({rc, iov, oen, clm}, {rs, rng, rs & (rng >= 4'hD), en, cl});
			rd({addr, 2'b10, rng, cl, en, rs, 4'h0});
			check(sdo_oe, 1'b0);
		end
		// Other address: no write, no drive
		wr({addr ^ 3'h1, 13'h0000}, 1'b0, 8'h00);
		check(rc, {rs, rng});
		i_odcs_host.xfer({addr ^ 3'h2, 1'b1, 12'h000}, 1'b1, 8'h00, r, drv);
		check(drv, 1'b0);
		// Corrupt checksum: dropped, flag raised, read clears it
		wr({addr, 13'h0000}, 1'b1, 8'h5A);
		check({rc, f_oe}, {rs, rng, 1'b1});
		rd({addr, 2'b10, rng, cl, en, rs, 4'h8});
		check(f_oe, 1'b0);
		// Each detector in turn
		for (int k = 0; k < 3; k++) begin
			{det_t, det_i, det_v} = 3'(3'h1 << k);
			i_odcs_host.tick(6);
			check(f_oe, 1'b1);
			rd({addr, 2'b10, rng, cl, en, rs, 1'b0, det_t, det_i, det_v});
			{det_t, det_i, det_v} = 3'h0;
			i_odcs_host.tick(6);
			check(f_oe, 1'b0);
		end
		wr({addr, 2'b00, rng, cl, en, rs, 4'h8}, 1'b0, 8'h00);
		check({clf, clm}, {1'b1, cl});
		wr({addr, 2'b01, 11'h000}, 1'b0, 8'h00);
		check({rc, oen, clf}, 16'h0000);
		// Hardware mode straps and fault pins
		rv = $urandom;
		rpins = rv[3:0];
		rpin = rv[4];
		hw = 1'b1;
		do_reset();
		check({hwm, rc, oen}, {1'b1, rpin, rpins, 1'b1});
		for (int k = 0; k < 4; k++) begin
			{det_t, det_i, det_v} = 3'(k + 3);
			i_odcs_host.tick(6);
			check({cf_oe, vf_oe, tf_oe, f_oe, cf, vf, tf}, {det_i, det_v, det_t, 4'h0});
		end
		i_odcs_host.xfer({addr, 1'b1, 12'h000}, 1'b1, 8'h00, r, drv);
		check(drv, 1'b0);
		results();
	end
endmodule
`default_nettype wire

// ==== verilog/odcs_crc8.sv ====
// Serial checksum engine, MSB first
`default_nettype none
module odcs_crc8 (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       clr_i,
	input  wire logic       en_i,
	input  wire logic       bit_i,
	output logic      [7:0] crc_o
);
	logic feedback;

	// Feedback from top bit and incoming data
	assign feedback = crc_o[7] ^ bit_i;

	// Shift register division
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || clr_i) begin
			crc_o <= odcs_pkg::CRC_INIT;
		end else if (en_i) begin
			crc_o <= {crc_o[6:0], 1'b0} ^ (feedback ? odcs_pkg::CRC_POLY : odcs_pkg::CRC_INIT); // [RQ20]
		end
	end
endmodule
`default_nettype wire

// ==== verilog/odcs_pkg.sv ====
// Package of constants and types for the output driver configuration and status block
// Notes on behaviour
// RQ1: Resistor select 1 with range 1101/1110/1111 picks internal-resistor overrange current ranges.
// RQ2: Clear-level select 0 clears to zero scale; 1 to midscale when unipolar.
// RQ3: Host sets output enable to 1; outputs stay disabled while it is 0.
// RQ4: Resistor select joins the four range bits to form the range code.
// RQ5: Readback starts with matching three-bit address and read/write bit 1.
// RQ6: Serial data output stays high impedance except during an addressed read.
// RQ7: Addressed read enables serial output and shifts data from fifth clock rise.
// RQ8: After readback, next frame sync rise returns serial output to high impedance.
// RQ9: One read transfer returns both control settings and status flags.
// RQ10: Read word: address, fixed 1 0, range, clear, enable, resistor, four flags.
// RQ11: Status flags are read-only; any set flag pulls the shared fault output low.
// RQ12: A received frame failing its checksum sets the interface-error flag.
// RQ13: Core temperature above about 150 C sets the overheat flag.
// RQ14: Open circuit on the current output sets the current fault flag.
// RQ15: Short circuit on the voltage output sets the voltage fault flag.
// RQ16: Hardware-select pin high means range comes from range and resistor pins.
// RQ17: Hardware mode has no status word; separate low fault pin per fault.
// RQ18: Hardware fault pins only pull low, never drive high.
// RQ19: Software mode fault output pulls low on headroom, short, checksum or overheat.
// RQ20: Host appends eight-bit checksum, polynomial x^8+x^2+x+1, after the data word.
// RQ21: On a 24-bit frame, checksum checked at sync rise; write only if good.
// RQ22: Reading the status word clears the interface-error flag and releases fault.
// RQ23: Clear command bit 1 forces outputs to the clear-level selected value.
// RQ24: Reset command returns every configuration bit and flag to power-on value.
`default_nettype none
package odcs_pkg;
	// Frame lengths in serial clocks
	localparam logic [4:0] FRAME_BITS     = 5'h10;
	localparam logic [4:0] CRC_FRAME_BITS = 5'h18;
	localparam logic [4:0] BIT_CNT_MAX    = 5'h1F;
	localparam logic [4:0] HDR_LAST_BIT   = 5'h03;
	localparam logic [4:0] BIT_CNT_STEP   = 5'h01;
	// Rising edges seen before the readback shift starts
	localparam logic [2:0] READ_START_RISE = 3'h4;
	localparam logic [2:0] RISE_CNT_MAX    = 3'h7;
	localparam logic [2:0] RISE_CNT_STEP   = 3'h1;
	// Checksum polynomial x^8+x^2+x+1 and start value
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	// Write word field positions
	localparam int ADDR_MSB   = 15;
	localparam int ADDR_LSB   = 13;
	localparam int RW_POS     = 12;
	localparam int RESET_POS  = 11;
	localparam int RANGE_MSB  = 10;
	localparam int RANGE_LSB  = 7;
	localparam int CLEAR_LEVEL_SELECT_POS = 6;
	localparam int OUTPUT_DRIVE_ENABLE_POS  = 5;
	localparam int SENSE_RESISTOR_SELECT_POS   = 4;
	localparam int CLEAR_POS  = 3;
	// Fixed pattern in the readback word
	localparam logic [1:0] READ_FIXED = 2'h2;
	// Internal-resistor overrange codes
	localparam logic [3:0] RANGE_OVR_392 = 4'hD;
	localparam logic [3:0] RANGE_OVR_204 = 4'hE;
	localparam logic [3:0] RANGE_OVR_245 = 4'hF;
	// Strap settling delay after reset release
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam logic [1:0] STRAP_STEP = 2'h1;
	// Synchroniser width: link 3, strap 1+3+4+1, detectors 3
	localparam int SYNC_W = 15;

	typedef struct packed {
		logic       sclk;
		logic       sync_n;
		logic       sdin;
	} odcs_link_t;

	typedef struct packed {
		logic       sense_resistor_select;
		logic [3:0] range_code;
		logic       clear_level_select;
		logic       output_drive_enable;
		logic       clear_cmd;
	} odcs_cfg_t;

	localparam odcs_cfg_t CFG_RESET = '0;

	typedef struct packed {
		logic       pec_error;
		logic       over_temp;
		logic       current_output_pin_fault;
		logic       voltage_output_pin_fault;
	} odcs_flags_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FRAME = 2'b01,
		ST_READ  = 2'b10
	} odcs_state_t;
endpackage
`default_nettype wire

// ==== verilog/odcs_sync.sv ====
// Two-stage synchroniser for pin inputs
`default_nettype none
module odcs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_ff;

	// First stage read only by the second
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_ff <= '0;
			sync_o  <= '0;
		end else begin
			meta_ff <= async_i;
			sync_o  <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/odcs_top.sv ====
// Configuration, readback and fault logic of the output driver
`default_nettype none
module odcs_top (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       sclk_i,
	input  wire logic       sync_n_i,
	input  wire logic       sdin_i,
	input  wire logic       hardware_mode_select_i,
	input  wire logic [2:0] device_address_i,
	input  wire logic [3:0] range_pins_i,
	input  wire logic       sense_resistor_pin_i,
	input  wire logic       current_output_pin_open_det_i,
	input  wire logic       voltage_output_pin_short_det_i,
	input  wire logic       overtemp_det_i,
	output logic            sdo_o,
	output logic            sdo_oe_o,
	output logic            fault_n_o,
	output logic            fault_n_oe_o,
	output logic            current_loop_fault_out_o,
	output logic            current_loop_fault_out_oe_o,
	output logic            voltage_short_fault_out_o,
	output logic            voltage_short_fault_out_oe_o,
	output logic            overtemp_fault_out_o,
	output logic            overtemp_fault_out_oe_o,
	output logic      [4:0] range_code_o,
	output logic            internal_overrange_o,
	output logic            output_drive_enable_o,
	output logic            clear_force_o,
	output logic            clear_midscale_o,
	output logic            hw_mode_o
);
	logic [odcs_pkg::SYNC_W-1:0] raw_in;
	logic [odcs_pkg::SYNC_W-1:0] syn_in;
	odcs_pkg::odcs_link_t        link;
	odcs_pkg::odcs_link_t        link_prev_ff;
	logic                        syn_hw;
	logic [2:0]                  syn_addr;
	logic [3:0]                  syn_range;
	logic                        syn_sense_resistor_select;
	logic                        syn_iopen;
	logic                        syn_vshort;
	logic                        syn_otemp;
	logic                        sclk_rise;
	logic                        sclk_fall;
	logic                        sync_rise;
	logic                        sync_fall;
	logic [1:0]                  strap_cnt_ff;
	logic                        hw_mode_ff;
	logic [2:0]                  addr_ff;
	odcs_pkg::odcs_state_t       state_ff;
	logic [23:0]                 shift_ff;
	logic [4:0]                  bit_cnt_ff;
	logic [2:0]                  rise_cnt_ff;
	logic [3:0]                  hdr_ff;
	logic [15:0]                 out_sh_ff;
	logic [7:0]                  crc;
	logic                        crc_ok;
	logic                        frame_end;
	logic                        len16;
	logic                        len24;
	logic [15:0]                 word;
	logic                        word_ok;
	logic                        wr_hit;
	logic                        pec_set;
	logic                        pec_clr;
	logic                        read_hit;
	odcs_pkg::odcs_cfg_t         cfg_ff;
	odcs_pkg::odcs_flags_t       flags_ff;
	logic [15:0]                 readback;
	logic                        range_ovr;

	// All pins pass two flops
	assign raw_in = {sclk_i, sync_n_i, sdin_i, hardware_mode_select_i, device_address_i,
	                 range_pins_i, sense_resistor_pin_i, current_output_pin_open_det_i, voltage_output_pin_short_det_i, overtemp_det_i};

	odcs_sync #(.WIDTH(odcs_pkg::SYNC_W)) u_sync (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i  (raw_in),
		.sync_o   (syn_in)
	);

	// Unpack synchronised inputs
	assign link       = syn_in[14:12];
	assign syn_hw     = syn_in[11];
	assign syn_addr   = syn_in[10:8];
	assign syn_range  = syn_in[7:4];
	assign syn_sense_resistor_select   = syn_in[3];
	assign syn_iopen  = syn_in[2];
	assign syn_vshort = syn_in[1];
	assign syn_otemp  = syn_in[0];

	// Link edge detection
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			link_prev_ff <= '0; // Same as synchroniser reset, so no false sync fall
		end else begin
			link_prev_ff <= link;
		end
	end

	assign sclk_rise = link.sclk & ~link_prev_ff.sclk;
	assign sclk_fall = ~link.sclk & link_prev_ff.sclk;
	assign sync_rise = link.sync_n & ~link_prev_ff.sync_n;
	assign sync_fall = ~link.sync_n & link_prev_ff.sync_n;

	// Straps caught once after reset release
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			strap_cnt_ff <= '0;
			hw_mode_ff   <= 1'b0;
			addr_ff      <= '0;
		end else if (strap_cnt_ff != odcs_pkg::STRAP_WAIT) begin
			strap_cnt_ff <= strap_cnt_ff + odcs_pkg::STRAP_STEP;
			hw_mode_ff   <= syn_hw; // [RQ16]
			addr_ff      <= syn_addr;
		end
	end

	// Frame decode
	assign frame_end = sync_rise && (state_ff == odcs_pkg::ST_FRAME);
	assign len16     = bit_cnt_ff == odcs_pkg::FRAME_BITS;
	assign len24     = bit_cnt_ff == odcs_pkg::CRC_FRAME_BITS;
	assign crc_ok    = crc == odcs_pkg::CRC_INIT;
	assign word      = len24 ? shift_ff[23:8] : shift_ff[15:0];
	assign word_ok   = len16 || (len24 && crc_ok); // [RQ21]
	assign wr_hit    = frame_end && word_ok && (word[odcs_pkg::ADDR_MSB:odcs_pkg::ADDR_LSB] == addr_ff)
	                   && !word[odcs_pkg::RW_POS];
	assign pec_set   = frame_end && len24 && !crc_ok; // [RQ12]
	assign pec_clr   = sync_rise && (state_ff == odcs_pkg::ST_READ); // [RQ22]
	assign read_hit  = sclk_rise && (rise_cnt_ff == odcs_pkg::READ_START_RISE)
	                   && (hdr_ff[3:1] == addr_ff) && hdr_ff[0]; // [RQ5]

	// Checksum over the frame bits received in ST_FRAME, before any readback starts
	odcs_crc8 u_crc (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.clr_i    (sync_fall),
		.en_i     (sclk_fall && (state_ff == odcs_pkg::ST_FRAME)),
		.bit_i    (link.sdin),
		.crc_o    (crc)
	);

	// Readback word: address, fixed bits, settings, flags
	assign readback = {addr_ff, odcs_pkg::READ_FIXED, cfg_ff.range_code, cfg_ff.clear_level_select,
	                   cfg_ff.output_drive_enable, cfg_ff.sense_resistor_select, flags_ff}; // [RQ9] [RQ10]

	// Frame state machine
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_ff <= odcs_pkg::ST_IDLE;
		end else begin
			unique case (state_ff)
				odcs_pkg::ST_IDLE: begin
					if (sync_fall && !hw_mode_ff) begin
						state_ff <= odcs_pkg::ST_FRAME;
					end
				end
				odcs_pkg::ST_FRAME: begin
					if (sync_rise) begin
						state_ff <= odcs_pkg::ST_IDLE;
					end else if (read_hit) begin
						state_ff <= odcs_pkg::ST_READ;
					end
				end
				odcs_pkg::ST_READ: begin
					if (sync_rise) begin
						state_ff <= odcs_pkg::ST_IDLE;
					end
				end
				default: state_ff <= odcs_pkg::ST_IDLE; // Unused code
			endcase
		end
	end

	// Input shift and bit counting on falling serial clock
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || sync_fall) begin
			shift_ff   <= '0;
			bit_cnt_ff <= '0;
			hdr_ff     <= '0;
		end else if (sclk_fall && (state_ff != odcs_pkg::ST_IDLE)) begin
			shift_ff <= {shift_ff[22:0], link.sdin};
			if (bit_cnt_ff != odcs_pkg::BIT_CNT_MAX) begin
				bit_cnt_ff <= bit_cnt_ff + odcs_pkg::BIT_CNT_STEP;
			end
			if (bit_cnt_ff == odcs_pkg::HDR_LAST_BIT) begin
				hdr_ff <= {shift_ff[2:0], link.sdin};
			end
		end
	end

	// Rising edge count within a frame
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || sync_fall) begin
			rise_cnt_ff <= '0;
		end else if (sclk_rise && (state_ff != odcs_pkg::ST_IDLE) && (rise_cnt_ff != odcs_pkg::RISE_CNT_MAX)) begin
			rise_cnt_ff <= rise_cnt_ff + odcs_pkg::RISE_CNT_STEP;
		end
	end

	// Serial data output, driven only in an addressed read
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sdo_oe_o  <= 1'b0;
			sdo_o     <= 1'b0;
			out_sh_ff <= '0;
		end else if (state_ff == odcs_pkg::ST_READ) begin
			if (sync_rise) begin
				sdo_oe_o <= 1'b0; // [RQ8]
			end else if (sclk_rise) begin
				sdo_o     <= out_sh_ff[15];
				out_sh_ff <= {out_sh_ff[14:0], 1'b0};
			end
		end else if (state_ff == odcs_pkg::ST_FRAME && read_hit && !sync_rise) begin
			sdo_oe_o  <= 1'b1; // [RQ7]
			sdo_o     <= readback[15];
			out_sh_ff <= {readback[14:0], 1'b0};
		end else begin
			sdo_oe_o <= 1'b0; // [RQ6]
		end
	end

	// Configuration written from checked frames
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_ff <= odcs_pkg::CFG_RESET;
		end else if (wr_hit) begin
			if (word[odcs_pkg::RESET_POS]) begin
				cfg_ff <= odcs_pkg::CFG_RESET; // [RQ24]
			end else begin
				cfg_ff.range_code            <= word[odcs_pkg::RANGE_MSB:odcs_pkg::RANGE_LSB];
				cfg_ff.sense_resistor_select <= word[odcs_pkg::SENSE_RESISTOR_SELECT_POS]; // [RQ4]
				cfg_ff.clear_level_select    <= word[odcs_pkg::CLEAR_LEVEL_SELECT_POS];
				cfg_ff.output_drive_enable   <= word[odcs_pkg::OUTPUT_DRIVE_ENABLE_POS];
				cfg_ff.clear_cmd             <= word[odcs_pkg::CLEAR_POS];
			end
		end
	end

	// Read-only flags: interface error sticky with set beating clear, the rest live
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			flags_ff <= '0;
		end else begin
			flags_ff.over_temp  <= syn_otemp; // [RQ13]
			flags_ff.current_output_pin_fault <= syn_iopen; // [RQ14]
			flags_ff.voltage_output_pin_fault <= syn_vshort; // [RQ15]
			if (pec_set) begin
				flags_ff.pec_error <= 1'b1; // [RQ12]
			end else if (pec_clr || (wr_hit && word[odcs_pkg::RESET_POS])) begin
				flags_ff.pec_error <= 1'b0; // [RQ22] [RQ24]
			end
		end
	end

	// Overrange decode for internal resistor
	assign range_ovr = cfg_ff.sense_resistor_select && ((cfg_ff.range_code == odcs_pkg::RANGE_OVR_392)
	                   || (cfg_ff.range_code == odcs_pkg::RANGE_OVR_204)
	                   || (cfg_ff.range_code == odcs_pkg::RANGE_OVR_245)); // [RQ1]

	// Range, enable and clear outputs
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			range_code_o          <= '0;
			internal_overrange_o  <= 1'b0;
			output_drive_enable_o <= 1'b0;
			clear_force_o         <= 1'b0;
			clear_midscale_o      <= 1'b0;
			hw_mode_o             <= 1'b0;
		end else begin
			hw_mode_o <= hw_mode_ff;
			if (hw_mode_ff) begin
				range_code_o          <= {syn_sense_resistor_select, syn_range}; // [RQ16]
				internal_overrange_o  <= syn_sense_resistor_select && ((syn_range == odcs_pkg::RANGE_OVR_392)
				                         || (syn_range == odcs_pkg::RANGE_OVR_204)
				                         || (syn_range == odcs_pkg::RANGE_OVR_245));
				output_drive_enable_o <= 1'b1;
				clear_force_o         <= 1'b0;
				clear_midscale_o      <= 1'b0;
			end else begin
				range_code_o          <= {cfg_ff.sense_resistor_select, cfg_ff.range_code}; // [RQ4]
				internal_overrange_o  <= range_ovr;
				output_drive_enable_o <= cfg_ff.output_drive_enable; // [RQ3]
				clear_force_o         <= cfg_ff.clear_cmd; // [RQ23]
				// Every range is unipolar, so select 1 means midscale
				clear_midscale_o      <= cfg_ff.clear_level_select; // [RQ2]
			end
		end
	end

	// Open-drain fault pins: low when enabled
	assign fault_n_o                 = 1'b0;
	assign current_loop_fault_out_o  = 1'b0; // [RQ18]
	assign voltage_short_fault_out_o = 1'b0; // [RQ18]
	assign overtemp_fault_out_o      = 1'b0; // [RQ18]
	// Pull-down enables: shared pin in software mode, one pin per fault in hardware mode
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fault_n_oe_o                 <= 1'b0;
			current_loop_fault_out_oe_o  <= 1'b0;
			voltage_short_fault_out_oe_o <= 1'b0;
			overtemp_fault_out_oe_o      <= 1'b0;
		end else begin
			fault_n_oe_o                 <= !hw_mode_ff && (|flags_ff); // [RQ11] [RQ19]
			current_loop_fault_out_oe_o  <= hw_mode_ff && flags_ff.current_output_pin_fault; // [RQ17]
			voltage_short_fault_out_oe_o <= hw_mode_ff && flags_ff.voltage_output_pin_fault; // [RQ17]
			overtemp_fault_out_oe_o      <= hw_mode_ff && flags_ff.over_temp; // [RQ17]
		end
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_read_open;
		read_hit && (state_ff == odcs_pkg::ST_FRAME) && !sync_rise;
	endsequence
	sequence s_read_driving;
		sdo_oe_o && (state_ff == odcs_pkg::ST_READ);
	endsequence
	property p_idle_hiz;
		(state_ff == odcs_pkg::ST_IDLE) && $past(state_ff == odcs_pkg::ST_IDLE) |-> !sdo_oe_o;
	endproperty
	a_idle_hiz: assert property (p_idle_hiz) else $error("serial output driven outside a read"); // [RQ6]
	property p_read_start;
		s_read_open |=> s_read_driving ##0 (sdo_o == $past(readback[15]));
	endproperty
	a_read_start: assert property (p_read_start) else $error("read did not start on fifth rise"); // [RQ7]
	property p_read_end;
		sync_rise && (state_ff == odcs_pkg::ST_READ) |=> !sdo_oe_o && (state_ff == odcs_pkg::ST_IDLE);
	endproperty
	a_read_end: assert property (p_read_end) else $error("serial output not released at sync rise"); // [RQ8]
	property p_fault_shared;
		!hw_mode_ff && $stable(hw_mode_ff) && (|flags_ff) |=> fault_n_oe_o;
	endproperty
	a_fault_shared: assert property (p_fault_shared) else $error("fault output not pulled low"); // [RQ11]
	property p_pec_set;
		pec_set |=> flags_ff.pec_error;
	endproperty
	a_pec_set: assert property (p_pec_set) else $error("checksum failure not flagged"); // [RQ12]
	property p_pec_clear;
		pec_clr && !pec_set |=> !flags_ff.pec_error ##1 (hw_mode_ff || fault_n_oe_o == (|flags_ff[2:0]) || !$stable(flags_ff));
	endproperty
	a_pec_clear: assert property (p_pec_clear) else $error("read did not clear interface error"); // [RQ22]
	property p_bad_crc_no_write;
		frame_end && len24 && !crc_ok |=> $stable(cfg_ff);
	endproperty
	a_bad_crc_no_write: assert property (p_bad_crc_no_write) else $error("bad checksum frame was written"); // [RQ21]
	property p_output_drive_enable_off;
		!hw_mode_ff && !cfg_ff.output_drive_enable ##1 !hw_mode_ff |-> !output_drive_enable_o;
	endproperty
	a_output_drive_enable_off: assert property (p_output_drive_enable_off) else $error("outputs enabled while enable bit clear"); // [RQ3]
	property p_overrange;
		!hw_mode_ff && cfg_ff.sense_resistor_select && (cfg_ff.range_code == odcs_pkg::RANGE_OVR_245)
		##1 !hw_mode_ff |-> internal_overrange_o && (range_code_o == {1'b1, odcs_pkg::RANGE_OVR_245});
	endproperty
	a_overrange: assert property (p_overrange) else $error("overrange range not selected"); // [RQ1]
	property p_hw_pin;
		hw_mode_ff && $stable(hw_mode_ff) && flags_ff.over_temp |=> overtemp_fault_out_oe_o && !fault_n_oe_o;
	endproperty
	a_hw_pin: assert property (p_hw_pin) else $error("hardware overheat pin not pulled low"); // [RQ17]
endmodule
`default_nettype wire
